// ---- verilog/api_inserter.sv ----
/*
  Ancillary packet inserter: holds a programmable packet and overwrites
  words of a passing video stream at a programmed line, field and offset.
  Assumes the upstream stream comes from logic on core_clk, marks each word
  with sample number since SAV, line, field, channel, link, stream tags and
  flags for audio or CRC words; a two-entry buffer absorbs receiver stalls.
*/

// Behaviour
// - Never overwrite embedded audio or CRC words.
// - Packet order: DID, SDID, DC, payload, checksum.
// - Payload store indexed 000 to 254; DC counts.
// - Output control: disabled, continuous, single packet.
// - Auto parity sends low 8 bits plus parity.
// - Store full 10 bits regardless of parity mode.
// - Accept 8-bit or 10-bit values per mode.
// - Confirmed clear wipes payload; cancel leaves it.
// - Checksum select: computed or programmed word.
// - Out-of-range line or offset suppresses insertion.
// - Timing reference words are not protected.
// - Progressive uses one programmed line number.
// - Interlaced: field one, two or both lines.
// - Sample offset counted from SAV, header start.
// - Insert on luma or chroma as selected.
// - Dual-link level B: link A or B.
// - Two HD streams: stream 1 or 2.
// - Parity defaults to automatic after reset.
module api_inserter #(
  parameter int unsigned LINE_W = 12,
  parameter int unsigned SAMP_W = 13
) (
  input  wire logic              core_clk,
  input  wire logic              rst,
  // Programming port.
  input  wire logic              wr_en,
  input  wire logic [7:0]        wr_addr,
  input  wire logic [9:0]        wr_data,
  input  wire logic              payload_clear_command,
  input  wire logic              clear_confirm,
  input  wire logic [9:0]        did_val,
  input  wire logic [9:0]        sdid_val,
  input  wire logic [9:0]        dc_val,
  input  wire logic [9:0]        cs_val,
  input  wire logic              cs_auto,
  input  wire logic              parity_manual,
  input  wire logic [1:0]        out_mode,
  input  wire logic              arm_single,
  input  wire logic              progressive,
  input  wire logic [1:0]        field_sel,
  input  wire logic [LINE_W-1:0] line_f1,
  input  wire logic [LINE_W-1:0] line_f2,
  input  wire logic [LINE_W-1:0] line_max,
  input  wire logic [SAMP_W-1:0] samp_off,
  input  wire logic [SAMP_W-1:0] samp_max,
  input  wire logic              sel_chroma,
  input  wire logic              fmt_3gb,
  input  wire logic              sel_link_b,
  input  wire logic              fmt_2hd,
  input  wire logic              sel_stream2,
  // Upstream video words.
  input  wire logic              in_valid,
  output logic                   in_ready,
  input  wire logic [9:0]        in_word,
  input  wire logic [LINE_W-1:0] in_line,
  input  wire logic              in_field2,
  input  wire logic [SAMP_W-1:0] in_samp,
  input  wire logic              in_chroma,
  input  wire logic              in_link_b,
  input  wire logic              in_stream2,
  input  wire logic              in_protect,
  // Downstream video words.
  output logic                   out_valid,
  input  wire logic              out_ready,
  output logic [9:0]             out_word,
  output logic                   busy
);

  // Module state except the output registers in one packed struct.
  typedef struct packed {
    logic [254:0][9:0] udw;     // Payload store, full 10-bit words.
    api_pkg::api_state_t st;    // Sequencer state.
    logic [7:0]        idx;     // Word index within current phase.
    logic [8:0]        sum;     // Running checksum.
    logic              armed;   // Single-packet arming.
    logic [1:0][9:0]   bw;      // Buffer words.
    logic [1:0]        bv;      // Buffer entry valid flags.
    logic              rd;      // Buffer read pointer.
    logic              wp;      // Buffer write pointer.
    logic              par_man; // Parity mode in force, manual when set.
  } api_reg_t;

  api_reg_t s_r;
  api_reg_t s_nxt;

  // Auto parity: even parity in bit 8, its inverse in bit 9.
  function automatic logic [9:0] api_par(input logic [9:0] w,
                                         input logic man);
    logic p;
    p = ^w[7:0];
    api_par = man ? w : {~p, p, w[7:0]};
  endfunction : api_par

  // Per-word match of the packet position and stream selection.
  logic hit_line;
  logic hit_pos;
  logic hit_sel;
  logic can_ins;
  logic start;
  logic push;
  logic [9:0] ins_word;
  logic [9:0] pk_word;
  logic [7:0] dc_n;

  // Line and field qualifier, range check and stream selection.
  always_comb begin
    hit_line = 1'b0;
    if (progressive) begin
      hit_line = (in_line == line_f1);
    end else begin
      // Field-dependent line choice.
      unique case (field_sel)
        api_pkg::FLD_ONE: hit_line = !in_field2 && in_line == line_f1;
        api_pkg::FLD_TWO: hit_line = in_field2 && in_line == line_f2;
        default: hit_line = in_field2 ? (in_line == line_f2)
                                      : (in_line == line_f1);
      endcase
    end
    // Offset counts from SAV; a position past the raster never fires.
    hit_pos = (in_samp == samp_off) && (samp_off <= samp_max) &&
              (in_line <= line_max);
    hit_sel = (in_chroma == sel_chroma) &&
              (!fmt_3gb || in_link_b == sel_link_b) &&
              (!fmt_2hd || in_stream2 == sel_stream2);
  end

  assign push = in_valid && in_ready;
  assign dc_n = dc_val[7:0];
  assign can_ins = (out_mode == api_pkg::OUT_CONT) ||
                   (out_mode == api_pkg::OUT_SINGLE && s_r.armed);
  assign start = s_r.st == api_pkg::API_IDLE && hit_line && hit_pos &&
                 hit_sel && can_ins;

  // Packet word for the current phase.
  always_comb begin
    pk_word = 10'h000;
    unique case (s_r.st)
      api_pkg::API_ADF: pk_word = (s_r.idx == 8'h00) ? api_pkg::ADF1
                                                     : api_pkg::ADF2;
      api_pkg::API_HDR: begin
        // Header words in order.
        unique case (s_r.idx)
          8'h00: pk_word = api_par(did_val, s_r.par_man);
          8'h01: pk_word = api_par(sdid_val, s_r.par_man);
          default: pk_word = api_par(dc_val, s_r.par_man);
        endcase
      end
      api_pkg::API_UDW: pk_word = api_par(s_r.udw[s_r.idx], s_r.par_man);
      api_pkg::API_CS: pk_word = cs_auto ? {~s_r.sum[8], s_r.sum}
                                 : api_par(cs_val, s_r.par_man);
      default: pk_word = api_pkg::ADF0;
    endcase
  end

  // Protected words pass through untouched; sync words are not spared.
  assign ins_word = (in_protect || !(start || s_r.st != api_pkg::API_IDLE))
                    ? in_word : pk_word;

  // Next-state logic for sequencer, payload store and buffer.
  always_comb begin
    s_nxt = s_r;
    // Parity mode follows its port one cycle later.
    s_nxt.par_man = parity_manual;
    // Payload write and clear; cancel simply never confirms.
    if (payload_clear_command && clear_confirm) begin
      s_nxt.udw = '0;
    end else if (wr_en && wr_addr < 8'(api_pkg::UDW_DEPTH)) begin
      s_nxt.udw[wr_addr] = wr_data;
    end
    if (arm_single) begin
      s_nxt.armed = 1'b1;
    end
    // Sequencer advances only on accepted stream words.
    if (push) begin
      // A packet word lost to a protected slot still counts in the sum.
      s_nxt.sum = s_r.sum + 9'(pk_word[8:0]);
      unique case (s_r.st)
        api_pkg::API_IDLE: begin
          if (start) begin
            s_nxt.st = api_pkg::API_ADF;
            s_nxt.idx = 8'h00;
            s_nxt.armed = 1'b0;
          end
        end
        api_pkg::API_ADF: begin
          s_nxt.sum = 9'h000;
          if (s_r.idx == 8'h01) begin
            s_nxt.st = api_pkg::API_HDR;
            s_nxt.idx = 8'h00;
          end else begin
            s_nxt.idx = s_r.idx + 8'h01;
          end
        end
        api_pkg::API_HDR: begin
          s_nxt.idx = s_r.idx + 8'h01;
          if (s_r.idx == 8'h02) begin
            s_nxt.idx = 8'h00;
            s_nxt.st = (dc_n == 8'h00) ? api_pkg::API_CS : api_pkg::API_UDW;
          end
        end
        api_pkg::API_UDW: begin
          s_nxt.idx = s_r.idx + 8'h01;
          if (s_r.idx == dc_n - 8'h01 || s_r.idx == 8'hfe) begin
            s_nxt.st = api_pkg::API_CS;
          end
        end
        default: begin
          s_nxt.st = api_pkg::API_IDLE;
        end
      endcase
    end
    // Two-entry buffer: write on push, drain on downstream accept.
    if (push) begin
      s_nxt.bw[s_r.wp] = ins_word;
      s_nxt.bv[s_r.wp] = 1'b1;
      s_nxt.wp = ~s_r.wp;
    end
    if (s_r.bv[s_r.rd] && out_ready) begin
      s_nxt.bv[s_r.rd] = push && (s_r.wp == s_r.rd);
      s_nxt.rd = ~s_r.rd;
    end
  end

  // State register.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
      // Parity comes up automatic until the port is first sampled.
      s_r.par_man <= !api_pkg::PARITY_AUTO_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Registered outputs.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      in_ready  <= 1'b0;
      out_valid <= 1'b0;
      out_word  <= 10'h000;
      busy      <= 1'b0;
    end else begin
      in_ready  <= !(s_nxt.bv[0] && s_nxt.bv[1]);
      out_valid <= s_nxt.bv[s_nxt.rd];
      out_word  <= s_nxt.bw[s_nxt.rd];
      busy      <= s_nxt.st != api_pkg::API_IDLE;
    end
  end

  // A protected word must leave the inserter unchanged.
  AST_PROTECT: assert property (@(posedge core_clk) disable iff (rst)
    push && in_protect |=> s_r.bw[$past(s_r.wp)] == $past(in_word))
    else $error("Protected word altered.");

  // The flag takes two more words before the header.
  AST_ADF_LEN: assert property (@(posedge core_clk) disable iff (rst)
    s_r.st == api_pkg::API_IDLE ##1 s_r.st == api_pkg::API_ADF |->
    s_r.idx == 8'h00)
    else $error("Flag sequence entered mid count.");

  // Single mode clears its arming once a packet starts.
  AST_SINGLE: assert property (@(posedge core_clk) disable iff (rst)
    push && start && !arm_single |=> !s_r.armed)
    else $error("Single packet not disarmed.");

  // Disabled output never starts a packet.
  AST_DISABLE: assert property (@(posedge core_clk) disable iff (rst)
    out_mode == api_pkg::OUT_DISABLE |-> !start)
    else $error("Insertion while disabled.");

  // A confirmed clear empties the store.
  AST_CLEAR: assert property (@(posedge core_clk) disable iff (rst)
    payload_clear_command && clear_confirm |=> s_r.udw == '0)
    else $error("Payload not cleared.");

  // Out-of-range offset blocks a start.
  AST_RANGE: assert property (@(posedge core_clk) disable iff (rst)
    samp_off > samp_max |-> !start)
    else $error("Insertion out of range.");

  // Header always follows the flag.
  AST_ORDER: assert property (@(posedge core_clk) disable iff (rst)
    $past(s_r.st) == api_pkg::API_ADF && s_r.st != api_pkg::API_ADF |->
    s_r.st == api_pkg::API_HDR)
    else $error("Header did not follow flag.");

  // Wrong channel blocks a start.
  AST_CHAN: assert property (@(posedge core_clk) disable iff (rst)
    in_chroma != sel_chroma |-> !start)
    else $error("Insertion on wrong channel.");

  // Buffer never reports ready while both entries are full.
  AST_BUF: assert property (@(posedge core_clk) disable iff (rst)
    s_r.bv == 2'h3 |-> !in_ready)
    else $error("Buffer overrun.");

  // The buffered automatic checksum carries inverted bit 8 in bit 9.
  AST_CS: assert property (@(posedge core_clk) disable iff (rst)
    push && s_r.st == api_pkg::API_CS && cs_auto && !in_protect |=>
    s_r.bw[$past(s_r.wp)][9] == ~s_r.bw[$past(s_r.wp)][8])
    else $error("Checksum bit 9 wrong.");

endmodule : api_inserter

// ---- inc/api_pkg.sv ----
/*
  Shared constants for the ancillary packet inserter.
  Assumes a single core_clk domain and an upstream video word stream.
*/
package api_pkg;
  // Number of payload words the store holds.
  localparam int unsigned UDW_DEPTH = 255;
  // Width of one stored or transmitted video word.
  localparam int unsigned WORD_W = 10;
  // Ancillary data flag words.
  localparam logic [9:0] ADF0 = 10'h000;
  localparam logic [9:0] ADF1 = 10'h3ff;
  localparam logic [9:0] ADF2 = 10'h3ff;
  // Output control encodings.
  localparam logic [1:0] OUT_DISABLE = 2'h0;
  localparam logic [1:0] OUT_CONT    = 2'h1;
  localparam logic [1:0] OUT_SINGLE  = 2'h2;
  // Field select encodings.
  localparam logic [1:0] FLD_ONE  = 2'h0;
  localparam logic [1:0] FLD_TWO  = 2'h1;
  localparam logic [1:0] FLD_BOTH = 2'h2;
  // Reset value of the parity mode: automatic.
  localparam logic PARITY_AUTO_RST = 1'b1;
  // Inserter sequencer states, Gray coded along the usual path from IDLE to CS.
  typedef enum logic [2:0] {
    API_IDLE = 3'h0,
    API_ADF  = 3'h1,
    API_HDR  = 3'h3,
    API_UDW  = 3'h2,
    API_CS   = 3'h6
  } api_state_t;
endpackage : api_pkg

// ---- tb/api_rx_model.sv ----
/*
  Downstream receiver model for the ancillary packet inserter.
  Assumes one core_clk domain; with slow high it stalls every other cycle.
*/
module api_rx_model (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       slow,
  input  wire logic       out_valid,
  input  wire logic [9:0] out_word,
  output logic            out_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [9:0] got [$];  // Words taken, oldest first.
  logic       ph_r;     // Stall phase, toggles every cycle.
  // Take a word on each handshake; stalling never drops a word.
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ph_r      <= 1'b0;
      out_ready <= 1'b0;
    end else begin
      ph_r      <= ~ph_r;
      out_ready <= ~(slow & ph_r);
      if (out_valid && out_ready) begin
        got.push_back(out_word);
      end
    end
  end
endmodule : api_rx_model

// ---- tb/test_api_inserter.sv ----
/*
  Self-checking bench for the ancillary packet inserter.
  Assumes api_inserter with default widths and the api_rx_model receiver.
*/
module test_api_inserter;
  timeunit 1ns;
  timeprecision 1ns;
  // Compares one value, counts it and reports a mismatch.
  `define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin \
    bad_count++; $display("ERROR %s expected %h seen %h", nm, e, g); end end
  logic        core_clk, rst, wr_en, payload_clear_command, clear_confirm;
  logic        cs_auto, parity_manual, arm_single, progressive, slow;
  logic        sel_chroma, fmt_3gb, sel_link_b, fmt_2hd, sel_stream2;
  logic        in_valid, in_field2, in_chroma, in_link_b, in_stream2;
  logic        in_protect, in_ready, out_valid, out_ready, busy;
  logic [7:0]  wr_addr;
  logic [9:0]  wr_data, did_val, sdid_val, dc_val, cs_val, in_word, out_word;
  logic [1:0]  out_mode, field_sel;
  logic [11:0] line_f1, line_f2, line_max, in_line;
  logic [12:0] samp_off, samp_max, in_samp;
  logic [9:0]  pay [255];  // Expected payload store.
  int          bad_count, checked;

  api_inserter uut (.core_clk, .rst, .wr_en, .wr_addr, .wr_data,
    .payload_clear_command, .clear_confirm, .did_val, .sdid_val, .dc_val,
    .cs_val, .cs_auto, .parity_manual, .out_mode, .arm_single, .progressive,
    .field_sel, .line_f1, .line_f2, .line_max, .samp_off, .samp_max,
    .sel_chroma, .fmt_3gb, .sel_link_b, .fmt_2hd, .sel_stream2, .in_valid,
    .in_ready, .in_word, .in_line, .in_field2, .in_samp, .in_chroma,
    .in_link_b, .in_stream2, .in_protect, .out_valid, .out_ready, .out_word,
    .busy);
  api_rx_model rx (.core_clk, .rst, .slow, .out_valid, .out_word, .out_ready);

  // The 10 MHz core clock.
  always #50 core_clk = ~core_clk;

  // Prints the counts and the verdict, then stops.
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : conclude

  // A handshake that never came ends the run as a failure.
  task automatic fail();
    $display("ERROR handshake expected done seen timeout");
    bad_count++;
    conclude();
  endtask : fail

  // Word as sent: manual keeps 10 bits, automatic adds parity to 8 bits.
  function automatic logic [9:0] par(input logic [9:0] w);
    if (parity_manual) return w;
    return {~(^w[7:0]), ^w[7:0], w[7:0]};
  endfunction : par

  // Word k of the packet, counted from the first flag word.
  function automatic logic [9:0] pkt(input int k);
    logic [8:0] s;
    int n;
    n = dc_val[7:0];
    if (k == 0) return 10'h000;
    if (k < 3) return 10'h3ff;
    if (k == 3) return par(did_val);
    if (k == 4) return par(sdid_val);
    if (k == 5) return par(dc_val);
    if (k < 6 + n) return par(pay[k-6]);
    if (!cs_auto) return par(cs_val);
    s = 9'(par(did_val) + par(sdid_val) + par(dc_val));
    for (int i = 0; i < n; i++) s += par(pay[i]);
    return {~s[8], s};
  endfunction : pkt

  // Writes one payload word.
  task automatic wr(input int a, input logic [9:0] d);
    wr_en   <= 1'b1;
    wr_addr <= a[7:0];
    wr_data <= d;
    @(posedge core_clk);
    wr_en <= 1'b0;
    @(posedge core_clk);
    pay[a] = d;
  endtask : wr

  // Issues a clear, confirmed or cancelled.
  task automatic clr(input logic c);
    payload_clear_command <= 1'b1;
    clear_confirm         <= c;
    @(posedge core_clk);
    payload_clear_command <= 1'b0;
    clear_confirm         <= 1'b0;
    @(posedge core_clk);
    if (c) pay = '{default: 10'h000};
  endtask : clr

  // Streams n words of one line and checks what comes out.
  task automatic run(input int n, input logic [11:0] ln, input logic ins,
                     input int pat);
    logic [9:0] want [$];
    logic [9:0] e;
    int k;
    int t;
    @(posedge core_clk);
    rx.got.delete();
    k = 0;
    for (int i = 0; i < n; i++) begin
      e = 10'h100 + i[9:0];
      in_valid   <= 1'b1;
      in_word    <= e;
      in_samp    <= i[12:0];
      in_line    <= ln;
      in_protect <= (i == pat);
      if (ins && i >= samp_off && k < 7 + dc_val[7:0]) begin
        if (i != pat) e = pkt(k);
        k++;
      end
      want.push_back(e);
      t = 0;
      do begin
        @(posedge core_clk);
        t++;
      end while (!in_ready && t < 100);
      if (!in_ready) fail();
      // Busy rises with the accepted start word and shows one word later.
      if (i == samp_off + 1) `CHK("busy", ins, busy)
    end
    in_valid <= 1'b0;
    for (t = 0; t < 3000 && rx.got.size() < n; t++) @(posedge core_clk);
    if (rx.got.size() < n) fail();
    for (int i = 0; i < n; i++) `CHK("out_word", want[i], rx.got[i])
  endtask : run

  // Main sequence.
  initial begin
    {core_clk, wr_en, payload_clear_command, clear_confirm, arm_single,
     in_valid, in_field2, in_chroma, in_link_b, in_stream2, in_protect,
     sel_chroma, fmt_3gb, sel_link_b, fmt_2hd, sel_stream2, parity_manual,
     slow, wr_addr, wr_data, in_word, in_line, in_samp, cs_val} = '0;
    {rst, cs_auto, progressive} = 3'h7;
    {did_val, sdid_val, dc_val} = {10'h041, 10'h005, 10'h003};
    out_mode = api_pkg::OUT_CONT;
    field_sel = api_pkg::FLD_ONE;
    {line_f1, line_f2, line_max} = {12'h009, 12'h014, 12'h1f4};
    {samp_off, samp_max} = {13'h0002, 13'h0064};
    pay = '{default: 10'h000};
    bad_count = 0;
    checked = 0;
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    clr(1'b1);
    wr(0, 10'h04c);
    wr(1, 10'h3a5);
    wr(2, 10'h0ff);
    wr(254, 10'h123);
    run(16, line_f1, 1, -1);
    slow <= 1'b1;
    run(16, line_f1, 1, 5);
    run(16, 12'h00a, 0, -1);
    parity_manual <= 1'b1;
    run(16, line_f1, 1, -1);
    cs_auto <= 1'b0;
    cs_val  <= 10'h2aa;
    clr(1'b0);
    run(16, line_f1, 1, -1);
    parity_manual <= 1'b0;
    samp_max <= 13'h0001;
    run(16, line_f1, 0, -1);
    samp_max <= 13'h0064;
    line_max <= 12'h008;
    run(16, line_f1, 0, -1);
    line_max <= 12'h1f4;
    sel_chroma <= 1'b1;
    run(16, line_f1, 0, -1);
    in_chroma <= 1'b1;
    run(16, line_f1, 1, -1);
    {fmt_3gb, sel_link_b} <= 2'h3;
    run(16, line_f1, 0, -1);
    in_link_b <= 1'b1;
    run(16, line_f1, 1, -1);
    {fmt_2hd, sel_stream2} <= 2'h3;
    run(16, line_f1, 0, -1);
    in_stream2 <= 1'b1;
    run(16, line_f1, 1, -1);
    out_mode <= api_pkg::OUT_DISABLE;
    run(16, line_f1, 0, -1);
    out_mode   <= api_pkg::OUT_SINGLE;
    arm_single <= 1'b1;
    @(posedge core_clk);
    arm_single <= 1'b0;
    run(16, line_f1, 1, -1);
    run(16, line_f1, 0, -1);
    out_mode    <= api_pkg::OUT_CONT;
    progressive <= 1'b0;
    field_sel   <= api_pkg::FLD_TWO;
    in_field2   <= 1'b1;
    run(16, line_f2, 1, -1);
    in_field2 <= 1'b0;
    run(16, line_f1, 0, -1);
    field_sel <= api_pkg::FLD_BOTH;
    run(16, line_f1, 1, -1);
    dc_val  <= 10'h0ff;
    cs_auto <= 1'b1;
    run(270, line_f1, 1, -1);
    conclude();
  end
endmodule : test_api_inserter
